// ---- pkg/gating_pkg.sv ----
// Shared constants and register map for the input gating control block.
package gating_pkg;
    localparam int unsigned SYSTEM_TIMEBASE_HZ       = 10_000_000;
    localparam int unsigned CLK_PERIOD_NS    = 100;
    // Stopwatch prescaler: two divide-by-100 stages then divide-by-10.
    localparam int unsigned SW_STAGE1_DIV    = 100;
    localparam int unsigned SW_STAGE2_DIV    = 100;
    localparam int unsigned SW_STAGE3_DIV    = 10;
    localparam int unsigned SW_TOTAL_DIV     = 100_000;
    // Fixed divide-by-ten mode of the high-frequency prescaler.
    localparam int unsigned HF_PSC_DIV       = 10;
    // Multiplier feedback dividers.
    localparam int unsigned MUL_LOW_DIV      = 100;
    localparam int unsigned MUL_MID_DIV      = 10;
    // Hold-off one-shot range in ms, and hold one-shot range in ms.
    localparam int unsigned HOLDOFF_MIN_MS   = 5;
    localparam int unsigned HOLDOFF_MAX_MS   = 500;
    localparam int unsigned HOLD_MIN_MS      = 200;
    localparam int unsigned HOLD_MAX_MS      = 10_000;
    localparam int unsigned CYC_PER_MS       = SYSTEM_TIMEBASE_HZ / 1000;
    localparam int unsigned HOLDOFF_MIN_CYC  = HOLDOFF_MIN_MS * CYC_PER_MS;
    localparam int unsigned HOLDOFF_MAX_CYC  = HOLDOFF_MAX_MS * CYC_PER_MS;
    localparam int unsigned HOLD_MIN_CYC     = HOLD_MIN_MS * CYC_PER_MS;
    localparam int unsigned HOLD_MAX_CYC     = HOLD_MAX_MS * CYC_PER_MS;
    localparam int unsigned TIMER_W          = 27;
    // Source select codes {C,B,A}.
    localparam logic [2:0] SEL_HF            = 3'h7;
    localparam logic [2:0] SEL_10M           = 3'h2;
    localparam logic [2:0] SEL_MUL           = 3'h1;
    localparam logic [2:0] SEL_SW            = 3'h3;
    // Priming shift register length and taps.
    localparam int unsigned PRIME_LEN        = 8;
    localparam int unsigned PRIME_TAP_A      = 1;
    localparam int unsigned PRIME_TAP_B      = 5;
    // APB register byte offsets.
    localparam logic [11:0] REG_CTRL         = 12'h000;
    localparam logic [11:0] REG_HOLDOFF      = 12'h004;
    localparam logic [11:0] REG_HOLD         = 12'h008;
    localparam logic [11:0] REG_STATUS       = 12'h00C;
    // Control field positions.
    localparam int unsigned CTRL_SEL_LSB     = 0;
    localparam int unsigned CTRL_LOW_N       = 3;
    localparam int unsigned CTRL_MID_N       = 4;
    localparam int unsigned CTRL_SWT_N       = 5;
    localparam int unsigned CTRL_AEDGE       = 6;
    localparam int unsigned CTRL_BEDGE       = 7;
    localparam int unsigned CTRL_SINGLE      = 8;
    localparam int unsigned CTRL_HOLD_BTN    = 9;
    localparam int unsigned CTRL_SINGLE_CLR  = 10;
    localparam int unsigned CTRL_FUNC_LSB    = 11;
    localparam logic [31:0] CTRL_RST         = 32'h0000_0038;
    localparam logic [31:0] HOLDOFF_RST      = 32'h0000_C350;
    localparam logic [31:0] HOLD_RST         = 32'h001E_8480;
endpackage

// ---- pkg/oneshot_if.sv ----
// Interface joining the main block to a one-shot timer instance.
`timescale 1ns/1ps
interface oneshot_if;
    logic                           trig;
    logic [gating_pkg::TIMER_W-1:0] period;
    logic                           busy;
    logic                           done;
    modport owner (output trig, output period, input busy, input done);
    modport timer (input trig, input period, output busy, output done);
endinterface

// ---- hdl/oneshot_timer.sv ----
// Retriggerable-free one-shot counter with a programmable terminal count.
`timescale 1ns/1ps
module oneshot_timer (
    input  wire logic   clk_i,
    input  wire logic   rst_n_i,
    oneshot_if.timer    os
);
    typedef struct packed {
        logic [gating_pkg::TIMER_W-1:0] cnt;
        logic                           busy;
        logic                           done;
    } os_state_t;
    os_state_t s_q;
    os_state_t s_d;

    always_comb begin
        s_d      = s_q;
        s_d.done = 1'b0;
        if (s_q.busy) begin
            if (s_q.cnt <= 27'h0000001) begin
                s_d.busy = 1'b0;
                s_d.done = 1'b1;
                s_d.cnt  = '0;
            end else begin
                s_d.cnt = s_q.cnt - 27'h0000001;
            end
        end else if (os.trig) begin
            s_d.busy = 1'b1;
            s_d.cnt  = os.period;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign os.busy = s_q.busy;
    assign os.done = s_q.done;

    AST_DONE_AFTER_BUSY: assert property (@(posedge clk_i)
        disable iff (!rst_n_i) os.done |-> $past(s_q.busy))
        else $error("one-shot done without a running period");
endmodule

// ---- hdl/clk_divider.sv ----
// Enable-pulse divider used for prescaler stages.
`timescale 1ns/1ps
module clk_divider #(
    parameter int unsigned DIV = 10
) (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic clr_i,
    input  wire logic en_i,
    output logic      tick_o
);
    typedef struct packed {
        logic [16:0] cnt;
    } div_state_t;
    div_state_t s_q;
    div_state_t s_d;

    always_comb begin
        s_d = s_q;
        if (clr_i) begin
            s_d.cnt = '0;
        end else if (en_i) begin
            if (s_q.cnt == 17'(DIV - 1)) begin
                s_d.cnt = '0;
            end else begin
                s_d.cnt = s_q.cnt + 17'h00001;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign tick_o = en_i && !clr_i && (s_q.cnt == 17'(DIV - 1));
endmodule

// ---- hdl/input_gating_ctrl.sv ----
// Input selection, gating, priming, reset and display hold control.
`timescale 1ns/1ps
module input_gating_ctrl (
    input  wire logic        SYSTEM_TIMEBASE_I,
    input  wire logic        NRST_I,
    input  wire logic        PSEL_I,
    input  wire logic        PENABLE_I,
    input  wire logic        PWRITE_I,
    input  wire logic [11:0] PADDR_I,
    input  wire logic [31:0] PWDATA_I,
    output logic      [31:0] PRDATA_O,
    output logic             PREADY_O,
    output logic             PSLVERR_O,
    input  wire logic        HF_PATH_I,
    input  wire logic        CHAN_A_I,
    input  wire logic        CHAN_B_I,
    input  wire logic        MUL_VCO_I,
    input  wire logic        START_BTN_I,
    input  wire logic        RESET_BTN_N_I,
    input  wire logic        REAR_RESET_N_I,
    input  wire logic        STORE_N_I,
    output logic             CHANNEL_A_TO_CORE_O,
    output logic             CHANNEL_B_TO_CORE_O,
    output logic             MUL_FEEDBACK_O,
    output logic             MULTIPLIER_INHIBIT_N_O,
    output logic             GATE_O,
    output logic             CORE_RESET_N_O,
    output logic             FREEZE_O,
    output logic             TRIG_LED_A_O,
    output logic             TRIG_LED_B_O
);
    typedef struct packed {
        logic [31:0]                      ctrl;
        logic [31:0]                      holdoff;
        logic [31:0]                      hold;
        logic [31:0]                      rdata;
        logic [2:0]                       hf_s;
        logic [2:0]                       ca_s;
        logic [2:0]                       cb_s;
        logic [2:0]                       vco_s;
        logic [2:0]                       st_s;
        logic [2:0]                       rb_s;
        logic [2:0]                       rr_s;
        logic [2:0]                       sto_s;
        logic                             hf_l;
        logic                             ca_l;
        logic                             cb_l;
        logic                             vco_l;
        logic                             st_l;
        logic                             rb_l;
        logic                             rr_l;
        logic                             sto_l;
        logic [3:0]                       hf_div;
        logic                             hf_out;
        logic [6:0]                       mul_div;
        logic                             mul_fb;
        logic                             sw_out;
        logic                             run;
        logic [gating_pkg::PRIME_LEN-1:0] prime;
        logic                             freeze;
        logic                             single_lock;
        logic [5:0]                       mode_prev;
        logic                             int_rst;
        logic [2:0]                       sel;
        logic                             a_out;
        logic                             b_out;
        logic                             led_a;
        logic                             led_b;
        logic                             gate;
        logic                             inh_n;
        logic                             rst_n_out;
        logic                             a_prev;
    } top_state_t;

    top_state_t s_q;
    top_state_t s_d;

    oneshot_if holdoff_os ();
    oneshot_if hold_os ();

    logic sw_t1;
    logic sw_t2;
    logic sw_t3;
    logic core_rst_n;

    // Synchronised level: second and third stages agree.
    function automatic logic settled(input logic [2:0] sh, input logic old);
        settled = (sh[1] == sh[2]) ? sh[2] : old;
    endfunction

    // Edges come from the settled level, so a one-cycle glitch on the
    // first stage can never count as a press or a clock edge.
    function automatic logic rising(input logic [2:0] sh, input logic old);
        rising = settled(sh, old) && !old;
    endfunction

    function automatic logic falling(input logic [2:0] sh, input logic old);
        falling = !settled(sh, old) && old;
    endfunction

    clk_divider #(.DIV(gating_pkg::SW_STAGE1_DIV)) sw_div1 (
        .clk_i  (SYSTEM_TIMEBASE_I),
        .rst_n_i(NRST_I),
        .clr_i  (!core_rst_n),
        .en_i   (1'b1),
        .tick_o (sw_t1)
    );
    clk_divider #(.DIV(gating_pkg::SW_STAGE2_DIV)) sw_div2 (
        .clk_i  (SYSTEM_TIMEBASE_I),
        .rst_n_i(NRST_I),
        .clr_i  (!core_rst_n),
        .en_i   (sw_t1),
        .tick_o (sw_t2)
    );
    clk_divider #(.DIV(gating_pkg::SW_STAGE3_DIV)) sw_div3 (
        .clk_i  (SYSTEM_TIMEBASE_I),
        .rst_n_i(NRST_I),
        .clr_i  (!core_rst_n),
        .en_i   (sw_t2),
        .tick_o (sw_t3)
    );

    oneshot_timer holdoff_tmr (
        .clk_i  (SYSTEM_TIMEBASE_I),
        .rst_n_i(NRST_I),
        .os     (holdoff_os.timer)
    );
    oneshot_timer hold_tmr (
        .clk_i  (SYSTEM_TIMEBASE_I),
        .rst_n_i(NRST_I),
        .os     (hold_os.timer)
    );

    logic ca_lvl;
    logic cb_lvl;
    logic a_slope;
    logic b_slope;
    logic low_n;
    logic mid_n;
    logic swt_n;
    logic single;
    logic apb_wr;
    logic apb_rd;
    logic [5:0] mode_now;

    always_comb begin
        low_n    = s_q.ctrl[gating_pkg::CTRL_LOW_N];
        mid_n    = s_q.ctrl[gating_pkg::CTRL_MID_N];
        swt_n    = s_q.ctrl[gating_pkg::CTRL_SWT_N];
        single   = s_q.ctrl[gating_pkg::CTRL_SINGLE];
        mode_now = {s_q.ctrl[gating_pkg::CTRL_FUNC_LSB +: 3],
                    s_q.ctrl[gating_pkg::CTRL_SEL_LSB +: 3]};
        ca_lvl   = settled(s_q.ca_s, s_q.ca_l);
        cb_lvl   = settled(s_q.cb_s, s_q.cb_l);
        a_slope  = ca_lvl ^ s_q.ctrl[gating_pkg::CTRL_AEDGE];
        b_slope  = cb_lvl ^ s_q.ctrl[gating_pkg::CTRL_BEDGE];
        apb_wr   = PSEL_I && PENABLE_I && PWRITE_I;
        apb_rd   = PSEL_I && !PENABLE_I && !PWRITE_I;
    end

    assign core_rst_n = s_q.rst_n_out;
    assign holdoff_os.trig   = s_q.a_prev && !a_slope;
    assign holdoff_os.period = s_q.holdoff[gating_pkg::TIMER_W-1:0];
    assign hold_os.trig      = falling(s_q.sto_s, s_q.sto_l);
    assign hold_os.period    = s_q.hold[gating_pkg::TIMER_W-1:0];

    always_comb begin
        s_d = s_q;
        // Three-stage input capture of every off-domain pin.
        s_d.hf_s  = {s_q.hf_s[1:0], HF_PATH_I};
        s_d.ca_s  = {s_q.ca_s[1:0], CHAN_A_I};
        s_d.cb_s  = {s_q.cb_s[1:0], CHAN_B_I};
        s_d.vco_s = {s_q.vco_s[1:0], MUL_VCO_I};
        s_d.st_s  = {s_q.st_s[1:0], START_BTN_I};
        s_d.rb_s  = {s_q.rb_s[1:0], RESET_BTN_N_I};
        s_d.rr_s  = {s_q.rr_s[1:0], REAR_RESET_N_I};
        s_d.sto_s = {s_q.sto_s[1:0], STORE_N_I};
        s_d.hf_l  = settled(s_q.hf_s, s_q.hf_l);
        s_d.ca_l  = ca_lvl;
        s_d.cb_l  = cb_lvl;
        s_d.vco_l = settled(s_q.vco_s, s_q.vco_l);
        s_d.st_l  = settled(s_q.st_s, s_q.st_l);
        s_d.rb_l  = settled(s_q.rb_s, s_q.rb_l);
        s_d.rr_l  = settled(s_q.rr_s, s_q.rr_l);
        s_d.sto_l = settled(s_q.sto_s, s_q.sto_l);

        if (apb_wr) begin
            unique case (PADDR_I)
                gating_pkg::REG_CTRL:    s_d.ctrl    = PWDATA_I;
                gating_pkg::REG_HOLDOFF: s_d.holdoff = PWDATA_I;
                gating_pkg::REG_HOLD:    s_d.hold    = PWDATA_I;
                default:                 s_d.rdata   = s_q.rdata;
            endcase
        end
        if (apb_rd) begin
            unique case (PADDR_I)
                gating_pkg::REG_CTRL:    s_d.rdata = s_q.ctrl;
                gating_pkg::REG_HOLDOFF: s_d.rdata = s_q.holdoff;
                gating_pkg::REG_HOLD:    s_d.rdata = s_q.hold;
                gating_pkg::REG_STATUS:  s_d.rdata = {24'h000000,
                    s_q.freeze, s_q.single_lock, hold_os.busy,
                    holdoff_os.busy, s_q.run, s_q.gate,
                    s_q.inh_n, s_q.rst_n_out};
                default:                 s_d.rdata = 32'h00000000;
            endcase
        end
        // The hold button and single-clear are self-clearing bits.
        if (!apb_wr) begin
            s_d.ctrl[gating_pkg::CTRL_HOLD_BTN]   = 1'b0;
            s_d.ctrl[gating_pkg::CTRL_SINGLE_CLR] = 1'b0;
        end

        s_d.mode_prev = mode_now;
        s_d.int_rst   = (mode_now != s_q.mode_prev);
        s_d.rst_n_out = s_d.rb_l && s_d.rr_l && !s_q.int_rst;

        if (rising(s_q.hf_s, s_q.hf_l)) begin
            if (s_q.hf_div == 4'(gating_pkg::HF_PSC_DIV / 2 - 1)) begin
                s_d.hf_div = 4'h0;
                s_d.hf_out = !s_q.hf_out;
            end else begin
                s_d.hf_div = s_q.hf_div + 4'h1;
            end
        end

        if (rising(s_q.vco_s, s_q.vco_l)) begin
            if (s_q.mul_div == 7'(gating_pkg::MUL_LOW_DIV - 1)) begin
                s_d.mul_div = 7'h00;
            end else begin
                s_d.mul_div = s_q.mul_div + 7'h01;
            end
        end
        if (!low_n) begin
            s_d.mul_fb = s_q.mul_div < 7'(gating_pkg::MUL_LOW_DIV / 2);
        end else if (!mid_n) begin
            s_d.mul_fb = (s_q.mul_div % 7'(gating_pkg::MUL_MID_DIV)) <
                         7'(gating_pkg::MUL_MID_DIV / 2);
        end else begin
            s_d.mul_fb = 1'b0;
        end
        s_d.inh_n = !low_n || !mid_n;

        if (sw_t3) begin
            s_d.sw_out = !s_q.sw_out;
        end

        if (rising(s_q.st_s, s_q.st_l)) begin
            s_d.run = !s_q.run;
        end
        if (!s_q.rst_n_out) begin
            s_d.run = 1'b0;
        end
        s_d.gate = !(s_q.run && !swt_n);

        if (s_q.ctrl[gating_pkg::CTRL_SINGLE_CLR]) begin
            s_d.prime = '0;
        end else begin
            s_d.prime = {s_q.prime[gating_pkg::PRIME_LEN-2:0], s_q.run};
        end

        s_d.sel = s_q.ctrl[gating_pkg::CTRL_SEL_LSB +: 3];
        s_d.a_prev = a_slope;
        if (single && s_q.prime[gating_pkg::PRIME_TAP_B] == 1'b0) begin
            s_d.a_out = !s_q.prime[gating_pkg::PRIME_TAP_A];
            s_d.b_out = 1'b1;
        end else if (single && s_q.prime != '1) begin
            s_d.a_out = 1'b0;
            s_d.b_out = 1'b0;
        end else begin
            unique case (s_q.sel)
                gating_pkg::SEL_HF:  s_d.a_out = !s_q.hf_out;
                gating_pkg::SEL_10M: s_d.a_out = a_slope;
                gating_pkg::SEL_MUL: s_d.a_out = s_q.mul_fb;
                gating_pkg::SEL_SW:  s_d.a_out = s_q.sw_out;
                default:             s_d.a_out = 1'b0;
            endcase
            s_d.a_out = s_d.a_out && !s_q.gate;
            s_d.b_out = holdoff_os.busy ? s_q.b_out : b_slope;
        end

        s_d.led_a = s_q.inh_n ? ca_lvl : s_d.a_out;
        s_d.led_b = !b_slope;

        if (hold_os.busy || s_q.ctrl[gating_pkg::CTRL_HOLD_BTN]) begin
            s_d.freeze = 1'b1;
            if (single && hold_os.busy) begin
                s_d.single_lock = 1'b1;
            end
        end else if (hold_os.done && !s_q.single_lock) begin
            s_d.freeze = 1'b0;
        end
        if (!s_q.rst_n_out) begin
            s_d.freeze      = 1'b0;
            s_d.single_lock = 1'b0;
        end
    end

    always_ff @(posedge SYSTEM_TIMEBASE_I or negedge NRST_I) begin
        if (!NRST_I) begin
            s_q         <= '0;
            s_q.ctrl    <= gating_pkg::CTRL_RST;
            s_q.holdoff <= gating_pkg::HOLDOFF_RST;
            s_q.hold    <= gating_pkg::HOLD_RST;
            s_q.gate    <= 1'b1;
            s_q.mode_prev <= {
                gating_pkg::CTRL_RST[gating_pkg::CTRL_FUNC_LSB +: 3],
                gating_pkg::CTRL_RST[gating_pkg::CTRL_SEL_LSB +: 3]};
        end else begin
            s_q <= s_d;
        end
    end

    assign PRDATA_O               = s_q.rdata;
    assign PREADY_O               = 1'b1;
    assign PSLVERR_O              = 1'b0;
    assign CHANNEL_A_TO_CORE_O    = s_q.a_out;
    assign CHANNEL_B_TO_CORE_O    = s_q.b_out;
    assign MUL_FEEDBACK_O         = s_q.mul_fb;
    assign MULTIPLIER_INHIBIT_N_O = s_q.inh_n;
    assign GATE_O                 = s_q.gate;
    assign CORE_RESET_N_O         = s_q.rst_n_out;
    assign FREEZE_O               = s_q.freeze;
    assign TRIG_LED_A_O           = s_q.led_a;
    assign TRIG_LED_B_O           = s_q.led_b;

    AST_INHIBIT_RANGE: assert property (@(posedge SYSTEM_TIMEBASE_I)
        disable iff (!NRST_I) s_q.inh_n |-> $past(!low_n || !mid_n))
        else $error("multiplier enabled outside its ranges");
    AST_GATE_OPEN: assert property (@(posedge SYSTEM_TIMEBASE_I)
        disable iff (!NRST_I) !s_q.gate |-> $past(s_q.run && !swt_n))
        else $error("gate opened without start in stopwatch mode");
    AST_RUN_RESET: assert property (@(posedge SYSTEM_TIMEBASE_I)
        disable iff (!NRST_I) !s_q.rst_n_out |=> !s_q.run)
        else $error("run state survived reset");
    AST_A_BLOCKED: assert property (@(posedge SYSTEM_TIMEBASE_I)
        disable iff (!NRST_I)
        (s_q.gate && !single) |=> !s_q.a_out)
        else $error("channel A passed while gate closed");
    AST_MODE_RESET: assert property (@(posedge SYSTEM_TIMEBASE_I)
        disable iff (!NRST_I)
        (mode_now != s_q.mode_prev) |-> ##2 !s_q.rst_n_out)
        else $error("no reset after mode change");
    AST_HOLD_BTN: assert property (@(posedge SYSTEM_TIMEBASE_I)
        disable iff (!NRST_I)
        (s_q.ctrl[gating_pkg::CTRL_HOLD_BTN] && s_q.rst_n_out)
        |=> s_q.freeze)
        else $error("hold button did not freeze");
    AST_PRIME_CLEAR: assert property (@(posedge SYSTEM_TIMEBASE_I)
        disable iff (!NRST_I)
        s_q.ctrl[gating_pkg::CTRL_SINGLE_CLR] |=> s_q.prime == '0)
        else $error("priming register not cleared");
    AST_SINGLE_LOCK: assert property (@(posedge SYSTEM_TIMEBASE_I)
        disable iff (!NRST_I)
        (s_q.single_lock && s_q.rst_n_out) |=> s_q.freeze)
        else $error("single freeze released before reset");
    AST_LED_B: assert property (@(posedge SYSTEM_TIMEBASE_I)
        disable iff (!NRST_I) NRST_I |=> s_q.led_b == !$past(b_slope))
        else $error("channel B indicator not inverted");

    COV_FREEZE: cover property (@(posedge SYSTEM_TIMEBASE_I)
        disable iff (!NRST_I) $rose(s_q.freeze));
    COV_GATE: cover property (@(posedge SYSTEM_TIMEBASE_I)
        disable iff (!NRST_I) $fell(s_q.gate));
    COV_HOLDOFF: cover property (@(posedge SYSTEM_TIMEBASE_I)
        disable iff (!NRST_I) $rose(holdoff_os.busy));
endmodule

// ---- tb/core_model.sv ----
// Behavioural stand-in for the measurement core that sits past the block.
`timescale 1ns/1ps
module core_model (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic store_req_i,
    output logic      store_n_o
);
    logic [1:0] left_q;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            left_q <= 2'h0;
        end else if (store_req_i) begin
            left_q <= 2'h3;
        end else if (left_q != 2'h0) begin
            left_q <= left_q - 2'h1;
        end
    end
    // Held low three clocks so the block's input synchroniser sees it.
    assign store_n_o = (left_q == 2'h0);
endmodule

// ---- tb/tb_top.sv ----
// Self-checking bench for the input gating control block.
`timescale 1ns/1ps
module tb_top;
    logic        clk = 1'b0, nrst = 1'b0, psel = 1'b0, pen = 1'b0;
    logic        pwr = 1'b0, hf = 1'b0, cha = 1'b0, chb = 1'b0, vco = 1'b0;
    logic        btn = 1'b0, rbn = 1'b1, rrn = 1'b1, sreq = 1'b0;
    logic [11:0] padr = 12'h000;
    logic [31:0] pwd = 32'h0, prd, rd;
    logic        prdy, perr, store_n, a_o, b_o, fb, inh_n, gate, crst_n;
    logic        frz, la, lb;
    int          n_fail = 0;
    int          check_count = 0;
    always #50 clk = ~clk;
    core_model i_core (.clk_i(clk), .rst_n_i(nrst), .store_req_i(sreq),
        .store_n_o(store_n));
    input_gating_ctrl i_dut (
        .SYSTEM_TIMEBASE_I(clk), .NRST_I(nrst), .PSEL_I(psel), .PENABLE_I(pen),
        .PWRITE_I(pwr), .PADDR_I(padr), .PWDATA_I(pwd), .PRDATA_O(prd),
        .PREADY_O(prdy), .PSLVERR_O(perr), .HF_PATH_I(hf), .CHAN_A_I(cha),
        .CHAN_B_I(chb), .MUL_VCO_I(vco), .START_BTN_I(btn),
        .RESET_BTN_N_I(rbn), .REAR_RESET_N_I(rrn), .STORE_N_I(store_n),
        .CHANNEL_A_TO_CORE_O(a_o), .CHANNEL_B_TO_CORE_O(b_o),
        .MUL_FEEDBACK_O(fb), .MULTIPLIER_INHIBIT_N_O(inh_n), .GATE_O(gate),
        .CORE_RESET_N_O(crst_n), .FREEZE_O(frz), .TRIG_LED_A_O(la),
        .TRIG_LED_B_O(lb));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // Called just after a rising edge; holds the request until pready.
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int i;
        psel <= 1'b1;
        pwr <= w;
        padr <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge clk);
            if (prdy === 1'b1) break;
        end
        if (i == 20) n_fail++;
        rd = prd;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask
    // Outputs are sampled on the falling edge, where they have settled.
    task automatic waitv(ref logic s, input logic v, input int n);
        int i;
        for (i = 0; i < n; i++) begin
            @(negedge clk);
            if (s === v) break;
        end
        chk(s, v);
        @(posedge clk);
    endtask
    task automatic t_reset;
        chk({gate, frz}, 2'h2);
        apb(1'b0, gating_pkg::REG_CTRL, 32'h0);
        chk(rd, gating_pkg::CTRL_RST);
        apb(1'b0, 12'h010, 32'h0);
        chk(rd, 32'h0);
    endtask
    task automatic t_inh;
        for (int k = 0; k < 4; k++) begin
            apb(1'b1, gating_pkg::REG_CTRL, {27'h0, k[1:0], 3'h2});
            waitv(inh_n, k != 3, 30);
        end
    endtask
    task automatic press;
        btn <= 1'b1;
        repeat (6) @(posedge clk);
        btn <= 1'b0;
    endtask
    // Five oscillator edges: the mid range feedback is low, the low one high.
    task automatic t_mul;
        apb(1'b1, gating_pkg::REG_CTRL, 32'h0000_000A);
        waitv(fb, 1'b1, 10);
        repeat (5) begin
            vco <= 1'b1;
            repeat (4) @(posedge clk);
            vco <= 1'b0;
            repeat (4) @(posedge clk);
        end
        waitv(fb, 1'b0, 10);
        apb(1'b1, gating_pkg::REG_CTRL, 32'h0000_0012);
        waitv(fb, 1'b1, 10);
    endtask
    task automatic t_gate;
        apb(1'b1, gating_pkg::REG_CTRL, 32'h0000_001A);
        press();
        waitv(gate, 1'b0, 30);
        cha <= 1'b1;
        chb <= 1'b1;
        repeat (10) @(posedge clk);
        chk({a_o, la, lb, b_o}, 4'hD);
        apb(1'b1, gating_pkg::REG_CTRL, 32'h0000_005A);
        waitv(a_o, 1'b0, 30);
        chb <= 1'b0;
        repeat (10) @(posedge clk);
        chk({b_o, lb}, 2'h3);
        press();
        waitv(gate, 1'b1, 30);
        cha <= 1'b0;
        repeat (10) @(posedge clk);
        chk(a_o, 1'b0);
        apb(1'b1, gating_pkg::REG_CTRL, 32'h0000_001B);
        waitv(crst_n, 1'b0, 20);
    endtask
    task automatic t_hold;
        apb(1'b1, gating_pkg::REG_HOLD, 32'h0000_0014);
        sreq <= 1'b1;
        @(posedge clk);
        sreq <= 1'b0;
        waitv(frz, 1'b1, 20);
        waitv(frz, 1'b0, 60);
        rbn <= 1'b0;
        waitv(crst_n, 1'b0, 20);
        rbn <= 1'b1;
        waitv(crst_n, 1'b1, 20);
        apb(1'b1, gating_pkg::REG_CTRL, 32'h0000_021B);
        repeat (100) @(posedge clk);
        chk(frz, 1'b1);
    endtask
    // Priming: channel A falls first, channel B some cycles later.
    task automatic t_single;
        apb(1'b1, gating_pkg::REG_CTRL, 32'h0000_051A);
        waitv(a_o, 1'b1, 10);
        chk(b_o, 1'b1);
        press();
        waitv(a_o, 1'b0, 30);
        chk(b_o, 1'b1);
        waitv(b_o, 1'b0, 10);
    endtask
    initial begin
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        repeat (8) @(posedge clk);
        t_reset();
        t_inh();
        t_mul();
        t_gate();
        t_hold();
        t_single();
        tally_and_finish();
    end
endmodule
